// file: src/rot_sub_alu_pkg.sv
/*
 * Shared constants for the rotate / subtract-with-borrow ALU slice:
 * register offsets on the Wishbone bus, flag positions, reset values,
 * widths and the operation encoding written by software.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
package rot_sub_alu_pkg;

    // Datapath and bus widths
    localparam int DATA_W    = 8;
    localparam int BUS_W     = 32;
    localparam int SEL_W     = 4;
    localparam int ADR_W     = 8;
    localparam int MEM_DEPTH = 16;
    localparam int MIDX_W    = 4;
    localparam int FLAG_W    = 6;
    localparam int OP_W      = 2;

    // Register byte offsets, one aligned word each
    localparam logic [ADR_W-1:0] OFF_CMD   = 8'h00;
    localparam logic [ADR_W-1:0] OFF_ACC   = 8'h04;
    localparam logic [ADR_W-1:0] OFF_IMM   = 8'h08;
    localparam logic [ADR_W-1:0] OFF_MIDX  = 8'h0C;
    localparam logic [ADR_W-1:0] OFF_MDATA = 8'h10;
    localparam logic [ADR_W-1:0] OFF_FLAGS = 8'h14;

    // Field positions inside the flag register
    localparam int FLAG_CARRY_POS  = 0;
    localparam int FLAG_NIL_POS    = 1;
    localparam int FLAG_RANGE_POS  = 2;
    localparam int FLAG_HALF_POS   = 3;
    localparam int FLAG_SIGNED_POS = 4;
    localparam int FLAG_CHAIN_POS  = 5;

    // Operation field position in the command register
    localparam int OP_LSB = 0;

    // Reset values
    localparam logic [DATA_W-1:0] ACC_RST   = 8'h00;
    localparam logic [DATA_W-1:0] IMM_RST   = 8'h00;
    localparam logic [DATA_W-1:0] MEM_RST   = 8'h00;
    localparam logic [MIDX_W-1:0] MIDX_RST  = 4'h0;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 6'h00;

    // Operation selected by a command write
    typedef enum logic [OP_W-1:0] {
        OP_ROT_CARRY_ACC,
        OP_SUB_MEM_ACC,
        OP_SUB_IMM_ACC,
        OP_SUB_MEM_MEM
    } alu_op_t;

endpackage : rot_sub_alu_pkg

// file: src/rotate_right_carry.sv
/*
 * Nine-bit rotate right through carry, purely combinational.
 * Assumes the caller decides where the result and carry are stored.
 */
`timescale 1ns/100ps
module rotate_right_carry
    import rot_sub_alu_pkg::*;
(
    // Operands
    input  wire logic [DATA_W-1:0] operand,
    input  wire logic              carryIn,
    // Results
    output logic      [DATA_W-1:0] result,
    output logic                   carryOut
);

    // Old carry enters the top, bit 0 leaves as carry
    assign result   = {carryIn, operand[DATA_W-1:1]};
    assign carryOut = operand[0];

endmodule : rotate_right_carry

// file: src/rotate_subtract_carry_alu.sv
/*
 * ALU slice for rotate right through carry into the accumulator and
 * three subtract-with-borrow forms, with the accumulator, an immediate
 * byte, a small flip-flop data memory and the status flags, all reached
 * over a classic Wishbone slave with 32-bit data.
 * Assumes one clock, synchronous active-high reset, and a master that
 * holds each request until it sees ack.
 * Assumes software loads the operands and the carry before it writes
 * the command register; every register is one byte in lane 0, and a
 * request is answered one cycle after it is taken.
 */
// Added by the designer: the placing of the registers and register access over Wishbone.
// Overview of operation
// - Rotate: accumulator bit i takes memory bit i+1 for bits 0 to 6.
// - Rotate: old carry into accumulator bit 7, memory bit 0 into carry only.
// - Rotate writes accumulator and carry only; the memory byte stays unchanged.
// - Memory subtract: accumulator minus memory minus inverted carry into accumulator.
// - Every subtract clears carry on negative result, sets it otherwise.
// - Every subtract updates all six arithmetic status flags.
// - Immediate subtract: accumulator minus immediate minus inverted carry into accumulator.
// - Memory-destination subtract writes memory byte, accumulator stays unchanged.
`timescale 1ns/100ps
module rotate_subtract_carry_alu
    import rot_sub_alu_pkg::*;
(
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Wishbone slave
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [ADR_W-1:0] adr_i,
    input  wire logic [SEL_W-1:0] sel_i,
    input  wire logic [BUS_W-1:0] dat_i,
    output logic      [BUS_W-1:0] dat_o,
    output logic                  ack_o
);

    // Architectural state; _q is the flop, _d its next value
    logic [DATA_W-1:0] acc_q;
    logic [DATA_W-1:0] acc_d;
    logic [DATA_W-1:0] imm_q;
    logic [MIDX_W-1:0] midx_q;
    logic [FLAG_W-1:0] flags_q;
    logic [FLAG_W-1:0] flags_d;
    logic [OP_W-1:0]   lastOp_q;

    // Data memory and its single write port
    logic [DATA_W-1:0] mem_q [MEM_DEPTH];
    logic [DATA_W-1:0] memWrData;
    logic              memWrEn;

    // Bus handshake state
    logic              ack_q;
    logic [BUS_W-1:0]  dat_q;

    // Bus decode
    logic              busReq;
    logic              wrTake;
    logic              laneLow;
    logic [ADR_W-3:0]  wordAdr;
    logic              hitCmd;
    logic              hitAcc;
    logic              hitImm;
    logic              hitMidx;
    logic              hitMdata;
    logic              hitFlags;
    logic              wrCmd;
    logic              wrAcc;
    logic              wrImm;
    logic              wrMidx;
    logic              wrMdata;
    logic              wrFlags;
    logic [DATA_W-1:0] wrByte;
    logic [DATA_W-1:0] rdByte;

    // Operation datapath
    alu_op_t           opSel;
    logic              execute;
    logic [DATA_W-1:0] memOperand;
    logic              carryNow;
    logic [DATA_W-1:0] subRhs;
    logic [DATA_W-1:0] rotResult;
    logic              rotCarry;
    logic [DATA_W-1:0] subResult;
    logic              subNoBorrow;
    logic              subHalf;
    logic              subRange;
    logic              subSigned;
    logic              subZero;
    logic [FLAG_W-1:0] subFlags;

    // Request is taken once; ack answers the following cycle
    assign busReq  = cyc_i & stb_i;
    // Writes land at the edge where the master samples ack high, so a
    // request held through its ack cycle writes exactly once
    assign wrTake  = busReq & we_i & ack_q;
    // Registers are one byte wide, so only the low lane matters
    assign laneLow = sel_i[0];
    assign wordAdr = adr_i[ADR_W-1:2];
    assign wrByte  = dat_i[DATA_W-1:0];

    // Word address decode
    assign hitCmd   = (wordAdr == OFF_CMD[ADR_W-1:2]);
    assign hitAcc   = (wordAdr == OFF_ACC[ADR_W-1:2]);
    assign hitImm   = (wordAdr == OFF_IMM[ADR_W-1:2]);
    assign hitMidx  = (wordAdr == OFF_MIDX[ADR_W-1:2]);
    assign hitMdata = (wordAdr == OFF_MDATA[ADR_W-1:2]);
    assign hitFlags = (wordAdr == OFF_FLAGS[ADR_W-1:2]);

    // Per-register write strobes
    assign wrCmd   = wrTake & laneLow & hitCmd;
    assign wrAcc   = wrTake & laneLow & hitAcc;
    assign wrImm   = wrTake & laneLow & hitImm;
    assign wrMidx  = wrTake & laneLow & hitMidx;
    assign wrMdata = wrTake & laneLow & hitMdata;
    assign wrFlags = wrTake & laneLow & hitFlags;

    // Read mux; unmapped words read as zero but are still acked, so a
    // stray access never stalls the master
    assign rdByte = hitCmd   ? {{(DATA_W-OP_W){1'b0}}, lastOp_q} :
                    hitAcc   ? acc_q :
                    hitImm   ? imm_q :
                    hitMidx  ? {{(DATA_W-MIDX_W){1'b0}}, midx_q} :
                    hitMdata ? mem_q[midx_q] :
                    hitFlags ? {{(DATA_W-FLAG_W){1'b0}}, flags_q} :
                               8'h00;

    // A command write starts the selected operation in that same edge;
    // the operation code travels in the write data, not in a register
    assign execute = wrCmd;
    assign opSel   = alu_op_t'(wrByte[OP_LSB +: OP_W]);

    // Operand fetch: both paths read the byte at the current index,
    // and the carry seen is the one held before this edge
    assign memOperand = mem_q[midx_q];
    assign carryNow   = flags_q[FLAG_CARRY_POS];

    // Immediate form takes its right operand from the immediate byte
    assign subRhs = (opSel == OP_SUB_IMM_ACC) ? imm_q : memOperand;

    // Rotate path
    rotate_right_carry rotUnit (
        .operand  (memOperand),
        .carryIn  (carryNow),
        .result   (rotResult),
        .carryOut (rotCarry)
    );

    // Subtract path, shared by the three subtract forms; one unit keeps
    // the flag terms identical between them
    sub_borrow_unit subUnit (
        .minuend       (acc_q),
        .subtrahend    (subRhs),
        .carryIn       (carryNow),
        .difference    (subResult),
        .noBorrow      (subNoBorrow),
        .halfNoBorrow  (subHalf),
        .rangeExceeded (subRange),
        .signedLess    (subSigned),
        .isZero        (subZero)
    );

    // Full flag set after a subtract; chained nil keeps multi-byte zero,
    // so a chain reads zero only when every byte of it was zero
    always_comb begin
        subFlags                  = '0;
        subFlags[FLAG_CARRY_POS]  = subNoBorrow;
        subFlags[FLAG_NIL_POS]    = subZero;
        subFlags[FLAG_RANGE_POS]  = subRange;
        subFlags[FLAG_HALF_POS]   = subHalf;
        subFlags[FLAG_SIGNED_POS] = subSigned;
        subFlags[FLAG_CHAIN_POS]  = subZero & flags_q[FLAG_CHAIN_POS];
    end

    // Next accumulator, flags and memory write for each operation; the
    // memory write data defaults to the difference, so the memory
    // destination form only has to raise the enable
    always_comb begin
        acc_d     = acc_q;
        flags_d   = flags_q;
        memWrEn   = 1'b0;
        memWrData = subResult;
        if (execute) begin
            // A command write owns the edge; no other register is addressed
            unique case (opSel)
                OP_ROT_CARRY_ACC: begin
                    // Only the carry bit moves; memory is left alone
                    acc_d                   = rotResult;
                    flags_d[FLAG_CARRY_POS] = rotCarry;
                    memWrEn                 = 1'b0;
                end
                OP_SUB_MEM_ACC: begin
                    acc_d   = subResult;
                    flags_d = subFlags;
                end
                OP_SUB_IMM_ACC: begin
                    acc_d   = subResult;
                    flags_d = subFlags;
                end
                OP_SUB_MEM_MEM: begin
                    // Result goes to memory, accumulator untouched
                    memWrEn = 1'b1;
                    flags_d = subFlags;
                end
            endcase
        end else begin
            // Plain register writes from software, lane 0 only
            if (wrAcc) begin
                acc_d = wrByte;
            end
            // Software may preload any flag, such as carry before a chain
            if (wrFlags) begin
                flags_d = wrByte[FLAG_W-1:0];
            end
            // Memory byte at the current index
            if (wrMdata) begin
                memWrEn   = 1'b1;
                memWrData = wrByte;
            end
        end
    end

    // Wishbone answer: ack one cycle after the request, then dropped;
    // read data is caught when the request is taken and stands until
    // the next request is taken
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= busReq & ~ack_q;
            if (busReq & ~ack_q) begin
                dat_q <= {{(BUS_W-DATA_W){1'b0}}, rdByte};
            end
        end
    end

    // Both bus outputs come straight from flops
    assign ack_o = ack_q;
    assign dat_o = dat_q;

    // Accumulator, eight bits wide throughout; only a command or a
    // direct write moves it
    always_ff @(posedge clock) begin
        if (rst) begin
            acc_q <= ACC_RST;
        end else begin
            acc_q <= acc_d;
        end
    end

    // Status flags; hardware writes them only on a command write and
    // software only on a flag write, so the two never meet in one edge
    always_ff @(posedge clock) begin
        if (rst) begin
            flags_q <= FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Immediate operand, written by software only; operations read it
    // but never change it
    always_ff @(posedge clock) begin
        if (rst) begin
            imm_q <= IMM_RST;
        end else if (wrImm) begin
            imm_q <= wrByte;
        end
    end

    // Memory index; upper data bits are dropped on purpose, so a large
    // index is cut to the low bits instead of reading nothing
    always_ff @(posedge clock) begin
        if (rst) begin
            midx_q <= MIDX_RST;
        end else if (wrMidx) begin
            midx_q <= wrByte[MIDX_W-1:0];
        end
    end

    // Last operation code written, kept for read-back only; it never
    // replays, since an operation runs only on the command write itself
    always_ff @(posedge clock) begin
        if (rst) begin
            lastOp_q <= '0;
        end else if (wrCmd) begin
            lastOp_q <= wrByte[OP_LSB +: OP_W];
        end
    end

    // Data memory in flip-flops; reset clears every byte, which costs
    // a wide reset fan-out but keeps reads defined from the start
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_q[i] <= MEM_RST;
            end
        end else if (memWrEn) begin
            mem_q[midx_q] <= memWrData;
        end
    end

endmodule : rotate_subtract_carry_alu

// file: src/sub_borrow_unit.sv
/*
 * Eight-bit subtract with borrow: minuend - subtrahend - not(carryIn).
 * Produces the difference and the flag terms derived from it.
 * Assumes carry means "no borrow", as the accumulator flags use it.
 */
`timescale 1ns/100ps
module sub_borrow_unit
    import rot_sub_alu_pkg::*;
(
    // Operands
    input  wire logic [DATA_W-1:0] minuend,
    input  wire logic [DATA_W-1:0] subtrahend,
    input  wire logic              carryIn,
    // Results
    output logic      [DATA_W-1:0] difference,
    output logic                   noBorrow,
    output logic                   halfNoBorrow,
    output logic                   rangeExceeded,
    output logic                   signedLess,
    output logic                   isZero
);

    logic [DATA_W:0] wideDiff;
    logic [4:0]      nibbleDiff;
    logic            borrowIn;

    // Borrow is the complement of carry
    assign borrowIn   = ~carryIn;
    assign wideDiff   = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrowIn};
    assign nibbleDiff = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrowIn};
    assign difference = wideDiff[DATA_W-1:0];

    // Negative means a borrow out of bit 7
    assign noBorrow      = ~wideDiff[DATA_W];
    assign halfNoBorrow  = ~nibbleDiff[4];
    // Overflow: operand signs differ and result sign left the minuend's
    assign rangeExceeded = (minuend[7] ^ subtrahend[7]) & (difference[7] ^ minuend[7]);
    // True signed less-than, corrected for overflow
    assign signedLess    = rangeExceeded ^ difference[7];
    assign isZero        = (difference == 8'h00);

endmodule : sub_borrow_unit

// file: testbench/rotate_subtract_carry_alu_asserts.sv
/*
 * Bus-side checker for the rotate / subtract ALU slice.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/100ps
module rotate_subtract_carry_alu_asserts
    import rot_sub_alu_pkg::*;
(
    // Clock and reset
    input wire logic             clock,
    input wire logic             rst,
    // Wishbone slave pins
    input wire logic             cyc_i,
    input wire logic             stb_i,
    input wire logic             we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [SEL_W-1:0] sel_i,
    input wire logic [BUS_W-1:0] dat_i,
    input wire logic [BUS_W-1:0] dat_o,
    input wire logic             ack_o
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // A request the slave must take
    wire takeReq = cyc_i && stb_i && !ack_o;
    wire readAck = ack_o && !we_i;

    property p_ackAfterTake; takeReq |=> ack_o; endproperty
    a_ackAfterTake: assert property (p_ackAfterTake) else $error("ack missing after request");
    property p_ackPulse; ack_o |=> !ack_o; endproperty
    a_ackPulse: assert property (p_ackPulse) else $error("ack wider than one cycle");
    property p_ackCause; ack_o |-> $past(takeReq); endproperty
    a_ackCause: assert property (p_ackCause) else $error("ack without a request");
    property p_readNarrow; readAck |-> dat_o[31:8] == 24'h0; endproperty
    a_readNarrow: assert property (p_readNarrow) else $error("read data above byte");
    property p_flagsNarrow;
        readAck && adr_i[7:2] == OFF_FLAGS[7:2] |-> dat_o[31:6] == 26'h0;
    endproperty
    a_flagsNarrow: assert property (p_flagsNarrow) else $error("flag read too wide");
    property p_unmapped; readAck && adr_i[7:2] > 6'h05 |-> dat_o == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // Read data may only move together with an acknowledge
    property p_dataHold; !ack_o |-> $stable(dat_o); endproperty
    a_dataHold: assert property (p_dataHold) else $error("read data moved without ack");
    property p_quietStart; $past(rst) |-> !ack_o && dat_o == 32'h0; endproperty
    a_quietStart: assert property (p_quietStart) else $error("bus busy right after reset");
endmodule : rotate_subtract_carry_alu_asserts

bind rotate_subtract_carry_alu rotate_subtract_carry_alu_asserts i_checker (
    .clock(clock), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));

// file: testbench/test_rotate_subtract_carry_alu.sv
/*
 * Self-checking bench for the rotate / subtract ALU slice.
 * Assumes the package offsets and flag positions; drives the bus itself.
 */
`timescale 1ns/100ps
module test_rotate_subtract_carry_alu
    import rot_sub_alu_pkg::*;
;
    logic             clock = 1'b0;
    logic             rst   = 1'b1;
    logic             cycI  = 1'b0;
    logic             stbI  = 1'b0;
    logic             weI   = 1'b0;
    logic [ADR_W-1:0] adrI  = 8'h00;
    logic [SEL_W-1:0] selI  = 4'h0;
    logic [BUS_W-1:0] datI  = 32'h0;
    logic [BUS_W-1:0] datO;
    logic             ackO;
    int               fails = 0;
    int               totalChecks = 0;
    logic [39:0]      expQ[$];
    logic [31:0]      lfsr = 32'hD7773217;

    // Clock generator, 25 ns period
    always #12.5 clock = ~clock;

    rotate_subtract_carry_alu i_dut (
        .clock(clock), .rst(rst), .cyc_i(cycI), .stb_i(stbI), .we_i(weI), .adr_i(adrI),
        .sel_i(selI), .dat_i(datI), .dat_o(datO), .ack_o(ackO));

    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nextRand

    // Reference subtract: returns flags above the byte result
    function automatic logic [13:0] subRef(input logic [7:0] a, b, input logic [5:0] f);
        logic [8:0] d;
        logic [4:0] h;
        logic [5:0] o;
        d = {1'b0, a} - {1'b0, b} - {8'h0, !f[FLAG_CARRY_POS]};
        h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, !f[FLAG_CARRY_POS]};
        o[FLAG_CARRY_POS]  = !d[8];
        o[FLAG_NIL_POS]    = d[7:0] == 8'h00;
        o[FLAG_RANGE_POS]  = (a[7] != b[7]) && (d[7] != a[7]);
        o[FLAG_HALF_POS]   = !h[4];
        o[FLAG_SIGNED_POS] = o[FLAG_RANGE_POS] ^ d[7];
        o[FLAG_CHAIN_POS]  = o[FLAG_NIL_POS] & f[FLAG_CHAIN_POS];
        return {o, d[7:0]};
    endfunction : subRef

    task automatic check(input string name, input logic [31:0] seen, exp);
        totalChecks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    // One classic cycle; request held until the edge that samples ack
    // high, released right after it, then one idle cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        cycI <= 1'b1;
        stbI <= 1'b1;
        weI  <= w;
        adrI <= a;
        datI <= d;
        selI <= s;
        do @(posedge clock); while (ackO !== 1'b1);
        cycI <= 1'b0;
        stbI <= 1'b0;
        weI  <= 1'b0;
        @(posedge clock);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, 4'h1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back({a, 24'h0, e});
        bus(1'b0, a, 32'h0, 4'hF);
    endtask : rd

    task tally_and_finish;
        $display("checks %0d, mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    // Read monitor; takes read data at the edge that samples ack high
    always @(posedge clock) begin
        if (ackO === 1'b1 && weI === 1'b0 && expQ.size() > 0) begin
            logic [39:0] e;
            e = expQ.pop_front();
            check($sformatf("reg %h", e[39:32]), datO, e[31:0]);
        end
    end

    // Main sequence
    initial begin
        logic [7:0] acc, imm, m, nAcc, nMem;
        logic [5:0] flg, nFlg;
        logic [1:0] op;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(OFF_ACC, ACC_RST);
        rd(OFF_FLAGS, {2'b00, FLAGS_RST});
        rd(OFF_IMM, IMM_RST);
        rd(OFF_MIDX, {4'h0, MIDX_RST});
        rd(OFF_MDATA, MEM_RST);
        rd(OFF_CMD, 8'h00);
        wr(8'h18, 8'hFF);
        rd(8'h18, 8'h00);
        bus(1'b1, OFF_ACC, 32'hFF, 4'hE); // Lane 0 disabled: ignored
        rd(OFF_ACC, 8'h00);
        for (int i = 0; i < 48; i++) begin
            lfsr = nextRand(lfsr);
            acc = lfsr[7:0];
            imm = lfsr[15:8];
            m   = lfsr[23:16];
            lfsr = nextRand(lfsr);
            flg = lfsr[5:0];
            if (i >= 40) begin // Equal operands; subtracts give zero when carry is set
                imm = acc;
                m   = acc;
            end
            op = i[1:0];
            wr(OFF_ACC, acc);
            wr(OFF_IMM, imm);
            wr(OFF_MIDX, {4'h0, lfsr[11:8]});
            wr(OFF_MDATA, m);
            wr(OFF_FLAGS, {2'b00, flg});
            nAcc = acc;
            nMem = m;
            nFlg = flg;
            case (op)
                2'd0: begin
                    nAcc = {flg[FLAG_CARRY_POS], m[7:1]};
                    nFlg[FLAG_CARRY_POS] = m[0];
                end
                2'd1: {nFlg, nAcc} = subRef(acc, m, flg);
                2'd2: {nFlg, nAcc} = subRef(acc, imm, flg);
                default: {nFlg, nMem} = subRef(acc, m, flg);
            endcase
            wr(OFF_CMD, {6'h0, op});
            rd(OFF_ACC, nAcc);
            rd(OFF_MDATA, nMem);
            rd(OFF_FLAGS, {2'b00, nFlg});
            rd(OFF_CMD, {6'h0, op});
            rd(OFF_IMM, imm);
            rd(OFF_MIDX, {4'h0, lfsr[11:8]});
        end
        tally_and_finish;
    end

    // Watchdog, well beyond the expected run of about 1760 cycles
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        tally_and_finish;
    end
endmodule : test_rotate_subtract_carry_alu
